// ==== include/wtc_defines.svh ====
// constants of the wide timer control block: offsets, fields, resets, counts
`ifndef WTC_DEFINES_SVH
`define WTC_DEFINES_SVH

// register byte offsets on the bus, low address byte only
`define WTC_OFS_CTRL_A       8'h00
`define WTC_OFS_CTRL_B       8'h04
`define WTC_OFS_STATUS       8'h08

// control register A fields
`define WTC_CA_FORCE_A_BIT   3
`define WTC_CA_FORCE_B_BIT   2
`define WTC_CA_STORE_MASK    8'hF3
`define WTC_CA_RESET         8'h00

// control register B fields
`define WTC_CB_STORE_MASK    8'hCF
`define WTC_CB_RESET         8'h00

// status register bit positions
`define WTC_ST_PIN_A_BIT     0
`define WTC_ST_PIN_B_BIT     1
`define WTC_ST_CAP_LVL_BIT   2
`define WTC_ST_EXT_LVL_BIT   3
`define WTC_ST_RUN_BIT       4

// prescaler: tick when the low bits of the divider are all ones
`define WTC_PRE_WIDTH        10
`define WTC_PRE_MASK_8       10'h007
`define WTC_PRE_MASK_64      10'h03F
`define WTC_PRE_MASK_256     10'h0FF
`define WTC_PRE_MASK_1024    10'h3FF

// noise canceler history: four equal samples
`define WTC_NOISE_ALL_HIGH   4'hF
`define WTC_NOISE_ALL_LOW    4'h0

`endif

// ==== include/wtc_pkg.sv ====
// types of the wide timer control block
package wtc_pkg;

	// compare output mode, one per channel
	typedef enum logic [1:0] {
		WTC_CM_OFF    = 2'h0,
		WTC_CM_TOGGLE = 2'h1,
		WTC_CM_CLEAR  = 2'h2,
		WTC_CM_SET    = 2'h3
	} wtc_cmp_mode_t;

	// pwm resolution select
	typedef enum logic [1:0] {
		WTC_PWM_OFF = 2'h0,
		WTC_PWM_8   = 2'h1,
		WTC_PWM_9   = 2'h2,
		WTC_PWM_10  = 2'h3
	} wtc_pwm_sel_t;

	// count source select
	typedef enum logic [2:0] {
		WTC_CS_STOP     = 3'h0,
		WTC_CS_CK       = 3'h1,
		WTC_CS_DIV8     = 3'h2,
		WTC_CS_DIV64    = 3'h3,
		WTC_CS_DIV256   = 3'h4,
		WTC_CS_DIV1024  = 3'h5,
		WTC_CS_EXT_FALL = 3'h6,
		WTC_CS_EXT_RISE = 3'h7
	} wtc_clk_sel_t;

	// control register A layout
	typedef struct packed {
		wtc_cmp_mode_t cmpAMode;
		wtc_cmp_mode_t cmpBMode;
		logic          forceCmpA;
		logic          forceCmpB;
		wtc_pwm_sel_t  pwmWidthSel;
	} wtc_ctrl_a_t;

	// control register B layout
	typedef struct packed {
		logic         captureNoiseFilterEn;
		logic         captureEdgeSel;
		logic [1:0]   reserved;
		logic         clearOnMatchA;
		wtc_clk_sel_t clkSel;
	} wtc_ctrl_b_t;

	// events from the counter's comparators
	typedef struct packed {
		logic matchA;
		logic matchB;
	} wtc_cnt_in_t;

	// controls toward the counter
	typedef struct packed {
		logic         countTick;
		logic         counterClear;
		logic         captureStrobe;
		logic         cmpFlagSetA;
		logic         cmpFlagSetB;
		wtc_pwm_sel_t pwmWidthSel;
		logic         pwmUpDown;
		logic         pwmWrapAtTop;
	} wtc_cnt_out_t;

endpackage : wtc_pkg

// ==== verilog/wtc_sync2.sv ====
// two flip-flop synchroniser for one pin
`timescale 1ns/1ps

module wtc_sync2 (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// pin side
	input  wire logic pinIn,
	// clock side
	output logic      syncOut
);

	logic meta_r;

	// the first stage feeds only the second stage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_r  <= 1'b0;
			syncOut <= 1'b0;
		end else begin
			meta_r  <= pinIn;
			syncOut <= meta_r;
		end
	end

endmodule : wtc_sync2

// ==== verilog/wtc_wide_timer_control.sv ====
// control logic of the 16-bit timer: registers, prescaler, capture, pins
// Notes on behaviour
// - control A holds channel A mode in 7:6, channel B mode in 5:4
// - non-pwm modes: 00 disconnect, 01 toggle, 10 low, 11 high on match
// - writing a force bit performs the programmed pin action at once
// - force written with new mode uses the old mode
// - forced compare sets no flag and never clears the counter
// - force bits read zero and do nothing while pwm is selected
// - control A 1:0 selects pwm: off, 8, 9 or 10 bits
// - filter off: capture on first sampled edge of selected polarity
// - filter on: four successive samples at new level before capture
// - edge select: zero captures on falling, one on rising edge
// - control B bits 5:4 always read zero
// - clear-on-match: counter cleared the cycle after a channel A match
// - in pwm the clear bit picks wrap at top, else up/down counting
// - clock select: stop, ck, /8, /64, /256, /1024, pin fall, pin rise
// - prescaled ticks come from the system clock; stop disables timer
// - external count pin counts even while configured as output
// - external count pin sampled on every rising system clock edge
// - real compare match sets its flag the cycle after the match
// - capture flag set in the same cycle the capture copy happens
`timescale 1ns/1ps
`include "wtc_defines.svh"

module wtc_wide_timer_control (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// ahb-lite slave
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic                 hready,
	input  wire logic [31:0]          hwdata,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// counter side
	input  wire wtc_pkg::wtc_cnt_in_t cntIn,
	output wtc_pkg::wtc_cnt_out_t     cntOut,
	// pins
	input  wire logic                 captureInPin,
	input  wire logic                 extCountPin,
	output logic                      cmpOutPinA,
	output logic                      cmpOutPinB,
	output logic                      cmpOutEnA,
	output logic                      cmpOutEnB
);

	wtc_pkg::wtc_ctrl_a_t ctrlA_r;
	wtc_pkg::wtc_ctrl_a_t ctrlA_nxt;
	wtc_pkg::wtc_ctrl_b_t ctrlB_r;
	wtc_pkg::wtc_ctrl_b_t ctrlB_nxt;
	logic                 wrPend_r;
	logic [7:0]           wrAddr_r;
	logic                 addrPhase;
	logic                 wrCtrlA;
	logic                 wrCtrlB;
	logic [31:0]          rdData_nxt;
	logic                 pwmOn;
	logic                 forceA;
	logic                 forceB;
	logic                 actA;
	logic                 actB;
	logic [`WTC_PRE_WIDTH-1:0] pre_r;
	logic                 tick_nxt;
	logic                 tick_r;
	logic                 extSync;
	logic                 extPrev_r;
	logic                 capSync;
	logic [3:0]           hist_r;
	logic                 capLevel_r;
	logic                 capLevel_nxt;
	logic                 capEdge;
	logic                 capture_r;
	logic                 clear_r;
	logic                 flagA_r;
	logic                 flagB_r;
	logic                 running;

	// pin synchronisers: nothing reads the pins before two flops
	wtc_sync2 uSyncExt (
		.clk     (clk),
		.reset   (reset),
		.pinIn   (extCountPin),
		.syncOut (extSync)
	);

	wtc_sync2 uSyncCap (
		.clk     (clk),
		.reset   (reset),
		.pinIn   (captureInPin),
		.syncOut (capSync)
	);

	// bus answers at once and never errs
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign addrPhase = hsel && htrans[1] && hready;

	// address phase of a write is remembered for its data phase
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			wrPend_r <= addrPhase && hwrite;
			wrAddr_r <= haddr[7:0];
		end
	end

	assign wrCtrlA = wrPend_r && (wrAddr_r == `WTC_OFS_CTRL_A);
	assign wrCtrlB = wrPend_r && (wrAddr_r == `WTC_OFS_CTRL_B);

	// force bits are never stored, reserved bits never stored
	always_comb begin
		ctrlA_nxt = ctrlA_r;
		ctrlB_nxt = ctrlB_r;
		if (wrCtrlA) begin
			ctrlA_nxt = wtc_pkg::wtc_ctrl_a_t'(hwdata[7:0]
				& `WTC_CA_STORE_MASK);
		end
		if (wrCtrlB) begin
			ctrlB_nxt = wtc_pkg::wtc_ctrl_b_t'(hwdata[7:0]
				& `WTC_CB_STORE_MASK);
		end
	end

	// control registers start cleared: stopped, no pwm, pins free
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ctrlA_r <= wtc_pkg::wtc_ctrl_a_t'(`WTC_CA_RESET);
			ctrlB_r <= wtc_pkg::wtc_ctrl_b_t'(`WTC_CB_RESET);
		end else begin
			ctrlA_r <= ctrlA_nxt;
			ctrlB_r <= ctrlB_nxt;
		end
	end

	// read mux looks at the next values so a read right after a write
	// sees the written data
	always_comb begin
		rdData_nxt = 32'h0000_0000;
		case (haddr[7:0])
			`WTC_OFS_CTRL_A: rdData_nxt[7:0] = ctrlA_nxt;
			`WTC_OFS_CTRL_B: rdData_nxt[7:0] = ctrlB_nxt;
			`WTC_OFS_STATUS: begin
				rdData_nxt[`WTC_ST_PIN_A_BIT]   = cmpOutPinA;
				rdData_nxt[`WTC_ST_PIN_B_BIT]   = cmpOutPinB;
				rdData_nxt[`WTC_ST_CAP_LVL_BIT] = capLevel_r;
				rdData_nxt[`WTC_ST_EXT_LVL_BIT] = extSync;
				rdData_nxt[`WTC_ST_RUN_BIT]     = running;
			end
			default: rdData_nxt = 32'h0000_0000;
		endcase
	end

	// read data held in a flop for the data phase
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hrdata <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata <= rdData_nxt;
		end
	end

	// pin action of one channel for a given mode
	function automatic logic pinAction(input wtc_pkg::wtc_cmp_mode_t mode,
		input logic cur);
		logic res;
		case (mode)
			wtc_pkg::WTC_CM_OFF:    res = cur;
			wtc_pkg::WTC_CM_TOGGLE: res = ~cur;
			wtc_pkg::WTC_CM_CLEAR:  res = 1'b0;
			wtc_pkg::WTC_CM_SET:    res = 1'b1;
			default:                res = cur;
		endcase
		return res;
	endfunction : pinAction

	// a force or a match outside pwm fires the pin action; pwm
	// waveforms are made by the pwm logic, not here
	assign pwmOn  = (ctrlA_r.pwmWidthSel != wtc_pkg::WTC_PWM_OFF);
	assign forceA = wrCtrlA && hwdata[`WTC_CA_FORCE_A_BIT] && !pwmOn;
	assign forceB = wrCtrlA && hwdata[`WTC_CA_FORCE_B_BIT] && !pwmOn;
	assign actA   = !pwmOn && (cntIn.matchA || forceA);
	assign actB   = !pwmOn && (cntIn.matchB || forceB);

	// mode taken from the register before this write lands
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cmpOutPinA <= 1'b0;
			cmpOutPinB <= 1'b0;
		end else begin
			if (actA) begin
				cmpOutPinA <= pinAction(ctrlA_r.cmpAMode, cmpOutPinA);
			end
			if (actB) begin
				cmpOutPinB <= pinAction(ctrlA_r.cmpBMode, cmpOutPinB);
			end
		end
	end

	// the timer owns the pin whenever a mode is set; port direction
	// is the port logic's business
	assign cmpOutEnA = (ctrlA_r.cmpAMode != wtc_pkg::WTC_CM_OFF);
	assign cmpOutEnB = (ctrlA_r.cmpBMode != wtc_pkg::WTC_CM_OFF);

	// flags and clear come only from real matches, never from a force
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			flagA_r <= 1'b0;
			flagB_r <= 1'b0;
			clear_r <= 1'b0;
		end else begin
			flagA_r <= cntIn.matchA;
			flagB_r <= cntIn.matchB;
			clear_r <= cntIn.matchA && ctrlB_r.clearOnMatchA
				&& !pwmOn;
		end
	end

	// prescaler runs on the system clock and restarts when stopped
	assign running = (ctrlB_r.clkSel != wtc_pkg::WTC_CS_STOP);
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pre_r <= '0;
		end else if (!running) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + `WTC_PRE_WIDTH'(1);
		end
	end

	// count source select
	always_comb begin
		tick_nxt = 1'b0;
		case (ctrlB_r.clkSel)
			wtc_pkg::WTC_CS_STOP:     tick_nxt = 1'b0;
			wtc_pkg::WTC_CS_CK:       tick_nxt = 1'b1;
			wtc_pkg::WTC_CS_DIV8:
				tick_nxt = ((pre_r & `WTC_PRE_MASK_8) == `WTC_PRE_MASK_8);
			wtc_pkg::WTC_CS_DIV64:
				tick_nxt = ((pre_r & `WTC_PRE_MASK_64) == `WTC_PRE_MASK_64);
			wtc_pkg::WTC_CS_DIV256:
				tick_nxt = ((pre_r & `WTC_PRE_MASK_256) == `WTC_PRE_MASK_256);
			wtc_pkg::WTC_CS_DIV1024:
				tick_nxt = (pre_r == `WTC_PRE_MASK_1024);
			wtc_pkg::WTC_CS_EXT_FALL: tick_nxt = extPrev_r && !extSync;
			wtc_pkg::WTC_CS_EXT_RISE: tick_nxt = !extPrev_r && extSync;
			default:                  tick_nxt = 1'b0;
		endcase
	end

	// tick flop and count pin history; pin read whatever its direction
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			extPrev_r <= 1'b0;
			tick_r    <= 1'b0;
		end else begin
			extPrev_r <= extSync;
			tick_r    <= tick_nxt;
		end
	end

	// filtered level moves only on four equal samples when filtering
	always_comb begin
		capLevel_nxt = capSync;
		if (ctrlB_r.captureNoiseFilterEn) begin
			if (hist_r == `WTC_NOISE_ALL_HIGH) begin
				capLevel_nxt = 1'b1;
			end else if (hist_r == `WTC_NOISE_ALL_LOW) begin
				capLevel_nxt = 1'b0;
			end else begin
				capLevel_nxt = capLevel_r;
			end
		end
	end

	// an edge counts only when its new level matches the selection
	assign capEdge = (capLevel_nxt != capLevel_r)
		&& (capLevel_nxt == ctrlB_r.captureEdgeSel);

	// four-sample history, level, and one strobe for both copy and flag
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			hist_r     <= 4'h0;
			capLevel_r <= 1'b0;
			capture_r  <= 1'b0;
		end else begin
			hist_r     <= {hist_r[2:0], capSync};
			capLevel_r <= capLevel_nxt;
			capture_r  <= capEdge;
		end
	end

	// controls toward the counter
	assign cntOut.countTick     = tick_r;
	assign cntOut.counterClear  = clear_r;
	assign cntOut.captureStrobe = capture_r;
	assign cntOut.cmpFlagSetA   = flagA_r;
	assign cntOut.cmpFlagSetB   = flagB_r;
	assign cntOut.pwmWidthSel   = ctrlA_r.pwmWidthSel;
	assign cntOut.pwmUpDown     = pwmOn && !ctrlB_r.clearOnMatchA;
	assign cntOut.pwmWrapAtTop  = pwmOn && ctrlB_r.clearOnMatchA;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	AST_CLEAR_AFTER_MATCH: assert property (
		cntIn.matchA && ctrlB_r.clearOnMatchA && !pwmOn
		|=> cntOut.counterClear
	) else $error("counter clear missing after match A");

	AST_FLAG_ONLY_FROM_MATCH: assert property (
		cntOut.cmpFlagSetA || cntOut.counterClear |-> $past(cntIn.matchA)
	) else $error("flag or clear without a real match");

	AST_FLAG_B_FOLLOWS: assert property (
		cntIn.matchB |=> cntOut.cmpFlagSetB
	) else $error("compare flag B not set after match");

	AST_TOGGLE_A: assert property (
		!pwmOn && ctrlA_r.cmpAMode == wtc_pkg::WTC_CM_TOGGLE
		&& cntIn.matchA |=> cmpOutPinA != $past(cmpOutPinA)
	) else $error("pin A did not toggle on match");

	AST_FORCE_OLD_MODE: assert property (
		forceA && ctrlA_r.cmpAMode == wtc_pkg::WTC_CM_SET
		|=> cmpOutPinA
	) else $error("forced set of pin A lost");

	AST_PWM_PIN_HOLD: assert property (
		pwmOn && !wrCtrlA ##1 pwmOn |-> $stable(cmpOutPinA)
	) else $error("pin A moved in pwm mode");

	AST_READ_ZERO_BITS: assert property (
		addrPhase && !hwrite && haddr[7:0] == `WTC_OFS_CTRL_B
		|=> hrdata[5:4] == 2'b00 && hrdata[31:8] == 24'h00_0000
	) else $error("reserved bits read nonzero");

	AST_FORCE_READ_ZERO: assert property (
		addrPhase && !hwrite && haddr[7:0] == `WTC_OFS_CTRL_A
		|=> hrdata[3:2] == 2'b00
	) else $error("force bits read nonzero");

	AST_CK_TICK: assert property (
		ctrlB_r.clkSel == wtc_pkg::WTC_CS_CK |=> cntOut.countTick
	) else $error("no tick with system clock source");

	AST_STOP_NO_TICK: assert property (
		cntOut.countTick |-> $past(running)
	) else $error("tick while stopped");

	AST_NOISE_FOUR: assert property (
		cntOut.captureStrobe && $past(ctrlB_r.captureNoiseFilterEn)
		|-> $past(hist_r) == `WTC_NOISE_ALL_HIGH
		|| $past(hist_r) == `WTC_NOISE_ALL_LOW
	) else $error("filtered capture without four equal samples");

endmodule : wtc_wide_timer_control

// ==== test/wtc_pin_model.sv ====
// pin-side model: capture pin, external count pin and compare pad
`timescale 1ns/1ps

module wtc_pin_model (
	// clock
	input  wire logic clk,
	// pins driven toward the block
	output logic      captureInPin,
	output logic      extCountPin,
	// compare pin from the block
	input  wire logic cmpOutPinA,
	input  wire logic cmpOutEnA,
	// level seen on the pad
	output logic      padA
);
	logic portLatchA;

	// pad shows the compare drive whenever cmpOutEnA is high, else the port latch
	assign padA = cmpOutEnA ? cmpOutPinA : portLatchA;

	// pins idle low between stimuli
	initial begin
		captureInPin = 1'b0;
		extCountPin  = 1'b0;
		portLatchA   = 1'b0;
	end

	// capture pin high for a number of clock cycles
	task automatic capPulse(input int w);
		captureInPin <= 1'b1;
		repeat (w) @(posedge clk);
		captureInPin <= 1'b0;
	endtask : capPulse

	// edges two cycles apart, wider than the one-cycle sampling limit
	task automatic extPulses(input int n);
		repeat (n) begin
			extCountPin <= 1'b1;
			repeat (2) @(posedge clk);
			extCountPin <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask : extPulses
endmodule : wtc_pin_model

// ==== test/test_wide_timer_control.sv ====
// self-checking bench of the wide timer control block
`timescale 1ns/1ps
`include "wtc_defines.svh"

module test_wide_timer_control;
	localparam logic [7:0] CA = `WTC_OFS_CTRL_A;
	localparam logic [7:0] CB = `WTC_OFS_CTRL_B;
	logic                  clk;
	logic                  reset;
	logic                  hsel;
	logic [31:0]           haddr;
	logic [1:0]            htrans;
	logic                  hwrite;
	logic [2:0]            hsize;
	logic [31:0]           hwdata;
	logic                  hreadyout;
	logic                  hresp;
	logic [31:0]           hrdata;
	wtc_pkg::wtc_cnt_in_t  cntIn;
	wtc_pkg::wtc_cnt_out_t cntOut;
	logic                  captureInPin;
	logic                  extCountPin;
	logic                  cmpOutPinA;
	logic                  cmpOutPinB;
	logic                  cmpOutEnA;
	logic                  cmpOutEnB;
	logic                  padA;
	int                    nErrors = 0;
	int                    totalChecks = 0;
	int                    cycles = 0;
	int                    nTick = 0;
	int                    nCap = 0;
	int                    nClr = 0;
	int                    nFlagA = 0;

	wtc_wide_timer_control i_wtc_wide_timer_control (
		.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .cntIn(cntIn), .cntOut(cntOut),
		.captureInPin(captureInPin), .extCountPin(extCountPin),
		.cmpOutPinA(cmpOutPinA), .cmpOutPinB(cmpOutPinB),
		.cmpOutEnA(cmpOutEnA), .cmpOutEnB(cmpOutEnB)
	);

	wtc_pin_model i_wtc_pin_model (
		.clk(clk), .captureInPin(captureInPin),
		.extCountPin(extCountPin), .cmpOutPinA(cmpOutPinA),
		.cmpOutEnA(cmpOutEnA), .padA(padA)
	);

	// 10 MHz system clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// pulse counters and the hang limit
	always @(posedge clk) begin
		cycles++;
		if (cntOut.countTick === 1'b1) nTick++;
		if (cntOut.captureStrobe === 1'b1) nCap++;
		if (cntOut.counterClear === 1'b1) nClr++;
		if (cntOut.cmpFlagSetA === 1'b1) nFlagA++;
		if (cycles == 20000) begin
			nErrors++;
			wrapUp();
		end
	end

	task automatic wrapUp();
		if (nErrors == 0 && totalChecks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : wrapUp

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		totalChecks++;
		if (g !== e) begin
			nErrors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// single write; the request stands until hready is seen high
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		haddr  <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clk); while (hreadyout !== 1'b1);
	endtask : wr

	// single read compared against an expected byte
	task automatic rc(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		haddr  <= {24'h0, a};
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		do @(posedge clk); while (hreadyout !== 1'b1);
		chk(nm, {24'h0, e}, hrdata);
	endtask : rc

	task automatic testRegs();
		rc(CA, 8'h00, "ctrlA reset");
		rc(CB, 8'h00, "ctrlB reset");
		chk("hreadyout", 1'b1, hreadyout);
		chk("hresp", 1'b0, hresp);
		chk("enable A", 1'b0, cmpOutEnA);
		wr(8'h0C, 8'hFF);
		rc(8'h0C, 8'h00, "unmapped");
		wr(CB, 8'hFF);
		rc(CB, 8'hCF, "ctrlB");
		wr(CA, 8'hFF);
		rc(CA, 8'hF3, "ctrlA");
		wr(CA, 8'h00);
		wr(CB, 8'h00);
	endtask : testRegs

	// set, clear and toggle modes on each channel, clear-on-match armed
	task automatic testCmp();
		logic [1:0] md[4] = '{2'h3, 2'h2, 2'h1, 2'h1};
		wr(CB, 8'h08);
		for (int ch = 0; ch < 2; ch++) begin
			for (int i = 0; i < 4; i++) begin
				wr(CA, {md[i], 6'h0} >> (2 * ch));
				cntIn <= (ch == 0) ? 2'b10 : 2'b01;
				@(posedge clk);
				cntIn <= 2'b00;
				#1;
				chk("pin", i % 2 == 0, ch ? cmpOutPinB : cmpOutPinA);
				chk("flag", 1'b1,
					ch ? cntOut.cmpFlagSetB : cntOut.cmpFlagSetA);
				chk("clear", ch == 0, cntOut.counterClear);
				chk("enable", 1'b1, ch ? cmpOutEnB : cmpOutEnA);
				if (ch == 0) chk("pad", i % 2 == 0, padA);
				@(posedge clk);
			end
		end
	endtask : testCmp

	task automatic testForce();
		int f;
		int c;
		wr(CA, 8'h80);
		f = nFlagA;
		c = nClr;
		wr(CA, 8'hC8);
		#1 chk("force old mode", 1'b0, cmpOutPinA);
		wr(CA, 8'hC8);
		#1 chk("force A", 1'b1, cmpOutPinA);
		wr(CA, 8'h81);
		wr(CA, 8'h89);
		#1 chk("force pwm", 1'b1, cmpOutPinA);
		rc(CA, 8'h81, "force read");
		repeat (2) @(posedge clk);
		#1 chk("force flag", f, nFlagA);
		chk("force clear", c, nClr);
		wr(CA, 8'h30);
		wr(CA, 8'h34);
		#1 chk("force B", 1'b1, cmpOutPinB);
		rc(8'h08, 8'h03, "status");
	endtask : testForce

	task automatic testPwm();
		for (int p = 0; p < 4; p++) begin
			for (int t = 0; t < 2; t++) begin
				wr(CA, p[7:0]);
				wr(CB, t ? 8'h08 : 8'h00);
				@(posedge clk);
				#1 chk("pwm sel", p, cntOut.pwmWidthSel);
				chk("updown", p > 0 && t == 0, cntOut.pwmUpDown);
				chk("wrap", p > 0 && t == 1, cntOut.pwmWrapAtTop);
			end
		end
		wr(CA, 8'h00);
	endtask : testPwm

	// windows are whole prescaler periods, so the count is exact
	task automatic testClk();
		int w[8] = '{64, 64, 64, 128, 512, 2048, 8, 8};
		int e[8] = '{0, 64, 8, 2, 2, 2, 5, 5};
		int s;
		for (int cs = 0; cs < 8; cs++) begin
			wr(CB, cs[7:0]);
			repeat (8) @(posedge clk);
			#1 s = nTick;
			if (cs > 5) i_wtc_pin_model.extPulses(5);
			repeat (w[cs]) @(posedge clk);
			#1 chk("ticks", e[cs], nTick - s);
		end
		wr(CB, 8'h00);
	endtask : testClk

	// edge polarity, then short and long pulses through the filter
	task automatic testCap();
		logic [7:0] cb[5] = '{8'h40, 8'h00, 8'hC0, 8'hC0, 8'h80};
		int wd[5] = '{3, 3, 3, 6, 6};
		int ex[5] = '{1, 1, 0, 1, 1};
		int s;
		for (int i = 0; i < 5; i++) begin
			wr(CB, cb[i]);
			#1 s = nCap;
			i_wtc_pin_model.capPulse(wd[i]);
			repeat (12) @(posedge clk);
			#1 chk("captures", ex[i], nCap - s);
		end
	endtask : testCap

	// main sequence
	initial begin
		reset  = 1'b1;
		hsel   = 1'b0;
		haddr  = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize  = 3'h2;
		hwdata = 32'h0000_0000;
		cntIn  = 2'b00;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		testRegs();
		testCmp();
		testForce();
		testPwm();
		testClk();
		testCap();
		wrapUp();
	end
endmodule : test_wide_timer_control
